// File: tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// register byte offsets
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_CMP 8'h04
`define TCC_OFF_CAP 8'h08
`define TCC_OFF_STAT 8'h0C

// reset values
`define TCC_CTRL_RST 9'h000
`define TCC_CMP_RST 16'hFFFF
`define TCC_CAP_RST 16'hFFFF

// control field positions
`define TCC_CTRL_W 9
`define TCC_CMP_HI_LANE 1

// status field positions
`define TCC_STAT_RUN_BIT 16

// source clock divider exponents (fc/2^n, fs/2^n)
`define TCC_DIV_W 11
`define TCC_DIV_SLOW 11
`define TCC_DIV_MID 7
`define TCC_DIV_FAST 3
`define TCC_FS_DIV 3

// pin filter, in fc cycles
`define TCC_FILT_REJECT_CYC 4
`define TCC_FILT_ACCEPT_CYC (`TCC_FILT_REJECT_CYC + 1)

// bus responses
`define TCC_RESP_OKAY 2'b00
`define TCC_RESP_SLVERR 2'b10

`endif

// File: tcc_pkg.sv
`default_nettype none
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_MODE_BASIC  = 2'h0,
    TCC_MODE_WINDOW = 2'h1,
    TCC_MODE_PULSE  = 2'h2,
    TCC_MODE_PPG    = 2'h3
  } tcc_mode_t;

  typedef enum logic [1:0] {
    TCC_RUN_STOP = 2'h0,
    TCC_RUN_SW   = 2'h1,
    TCC_RUN_RISE = 2'h2,
    TCC_RUN_FALL = 2'h3
  } tcc_run_t;

  typedef struct packed {
    logic      trigger_stop_sel;
    logic      capture_edge_count_sel;
    logic      auto_capture_en;
    tcc_run_t  run_edge_sel;
    logic [1:0] source_clock_sel;
    tcc_mode_t operating_mode_sel;
  } tcc_ctrl_t;

endpackage
`default_nettype wire

// File: tcc_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_pulse_src (
  // clock
  input  wire logic i_clk,
  // counting pin
  output var logic  o_pin
);
  initial o_pin = 1'b0;
  // holds the pin at v for w clocks; only the filter scenario asks below 12
  task automatic lvl(input logic v, input int w);
    @(posedge i_clk);
    o_pin <= v;
    repeat (w - 1) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: tcc_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_slow_mode = 1'b0, i_stop_mode = 1'b0;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic        i_prescaler_tap_sel = 1'b0, i_fs_tick = 1'b0, i_count_input_pin;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [2:0]  i_s_axi_awprot = 3'h0, i_s_axi_arprot = 3'h0;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, got;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic        o_s_axi_rvalid, o_timer_match_irq, p = 1'b0;
  logic [67:0] exp_q [$];
  logic [67:0] note;
  logic [1:0]  bexp_q [$];
  logic [1:0]  ck [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  int          per [5] = '{2048, 128, 128, 8, 128};
  int          cyc = 0, irqs = 0, stamp = 0, miscompares = 0, total_checks = 0;
  int          seed = 32'h600C, k, t0, cmp;
  tcc_timer_counter i_tcc_timer_counter (.*);
  tcc_pulse_src i_tcc_pulse_src (.i_clk(i_clk), .o_pin(i_count_input_pin));
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    i_fs_tick <= (cyc % 16 == 15);
    if (o_timer_match_irq) begin
      irqs <= irqs + 1;
      stamp <= cyc;
    end
  end
  always @(posedge i_clk) begin
    if (o_s_axi_rvalid && i_s_axi_rready) begin
      note = exp_q.pop_front();
      check("read", {o_s_axi_rresp, o_s_axi_rdata} & note[67:34], note[33:0]);
    end
    if (o_s_axi_bvalid && i_s_axi_bready) begin
      check("bresp", 34'(o_s_axi_bresp), 34'(bexp_q.pop_front()));
    end
  end
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hung;
    miscompares++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] r = 2'h0);
    logic done;
    @(posedge i_clk);
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= s;
    i_s_axi_bready <= 1'b1;
    bexp_q.push_back(r);
    done = 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      done = o_s_axi_bvalid;
    end
    i_s_axi_bready <= 1'b0;
    if (!done) hung();
  endtask
  // the note goes in before the request, so the watcher always finds it
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m = '1);
    logic done;
    @(posedge i_clk);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr <= a;
    i_s_axi_rready <= 1'b1;
    exp_q.push_back({m, e & m});
    done = 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      done = o_s_axi_rvalid;
    end
    got = o_s_axi_rdata;
    i_s_axi_rready <= 1'b0;
    if (!done) hung();
  endtask
  task automatic wait_irq(input int lim);
    int k0;
    k0 = irqs;
    for (int n = 0; n < lim && irqs == k0; n++) @(posedge i_clk);
    if (irqs == k0) hung();
  endtask
  task automatic pulse(input int w);
    i_tcc_pulse_src.lvl(!p, w);
    i_tcc_pulse_src.lvl(p, 24);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hFFFF);
    wr(8'h08, 32'h1234);
    rd(8'h08, 32'hFFFF);
    wr(8'h0C, 32'h5);
    rd(8'h0C, 32'h0);
    rd(8'h10, {2'h2, 32'h0});
    wr(8'hFC, 32'h1, 4'hF, 2'h2);
    for (int i = 0; i < 5; i++) begin
      cmp = (i == 3) ? 2 + ($random(seed) & 15) : 2;
      i_prescaler_tap_sel <= (i == 1);
      i_slow_mode <= (i == 4);
      wr(8'h00, {28'h0, ck[i], 2'h0});
      wr(8'h04, 32'(cmp));
      if (i == 2) wr(8'h04, 32'h5, 4'h1);
      wr(8'h00, {26'h0, 2'h1, ck[i], 2'h0});
      wait_irq(4 * (cmp + 1) * per[i]);
      t0 = stamp;
      wait_irq(4 * (cmp + 1) * per[i]);
      check("period", 34'(stamp - t0), 34'((cmp + 1) * per[i]));
    end
    // slow mode: the mid code must give no ticks at all
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h14);
    k = irqs;
    repeat (400) @(posedge i_clk);
    check("slow gated", 34'(irqs - k), 34'h0);
    i_slow_mode <= 1'b0;
    i_stop_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_stop_mode <= 1'b0;
    rd(8'h00, 32'h4);
    rd(8'h0C, 32'h0);
    k = irqs;
    repeat (200) @(posedge i_clk);
    check("stopped", 34'(irqs - k), 34'h0);
    wr(8'h04, 32'hA);
    for (int j = 1; j >= 0; j--) begin
      wr(8'h00, 32'h8);
      wr(8'h00, {23'h0, j[0], 8'h28});
      k = irqs;
      pulse(40);
      repeat (150) @(posedge i_clk);
      check("early edge", 34'(irqs - k), 34'(1 - j));
      pulse(200);
      check("trigger match", 34'(irqs - k), 34'(2 - j));
      rd(8'h0C, 32'h0, 34'hFFFF);
    end
    for (int j = 0; j < 2; j++) begin
      p = j[0];
      wr(8'h00, 32'hC);
      i_tcc_pulse_src.lvl(p, 20);
      wr(8'h04, 32'h2);
      wr(8'h00, {24'h0, 2'h1, j ? 2'h3 : 2'h2, 4'hC});
      pulse(3);
      rd(8'h0C, 32'h1_0000);
      pulse(30);
      rd(8'h0C, 32'h1_0001);
      rd(8'h08, 32'h0);
      k = irqs;
      i_tcc_pulse_src.lvl(!p, 40);
      check("count edge", 34'(irqs - k), 34'h0);
      i_tcc_pulse_src.lvl(p, 40);
      check("opposite edge", 34'(irqs - k), 34'h1);
      wr(8'h00, 32'h8);
      wr(8'h04, 32'h100);
      wr(8'h00, {24'h0, 2'h0, j ? 2'h3 : 2'h2, 4'h9});
      pulse(160);
      rd(8'h0C, 32'h0, 34'h0);
      check("window", 34'(got[15:0] >= 18 && got[15:0] <= 22), 34'h1);
    end
    p = 1'b0;
    wr(8'h00, 32'h8);
    i_tcc_pulse_src.lvl(1'b0, 20);
    wr(8'h00, 32'hAA);
    k = irqs;
    // both widths after start are captured, each with an interrupt
    pulse(200);
    pulse(200);
    check("single", 34'(irqs - k), 34'h2);
    rd(8'h0C, 32'h1, 34'hFFFF);
    rd(8'h08, 32'h0, 34'h0);
    check("width", 34'(got[15:0] >= 24 && got[15:0] <= 28), 34'h1);
    wr(8'h00, 32'h8);
    wr(8'h00, 32'h2A);
    k = irqs;
    i_tcc_pulse_src.lvl(1'b1, 200);
    i_tcc_pulse_src.lvl(1'b0, 104);
    i_tcc_pulse_src.lvl(1'b1, 30);
    check("double", 34'(irqs - k), 34'h2);
    rd(8'h08, 32'h0, 34'h0);
    check("cycle", 34'(got[15:0] >= 36 && got[15:0] <= 40), 34'h1);
    conclude();
  end
endmodule
`default_nettype wire

// File: tcc_timer_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcc_map.svh"

// Operation
// - four modes chosen by the operating mode field in the control register
// - timer mode counts source clock; match raises interrupt, clears, keeps counting
// - auto capture copies counter into capture register every source clock edge
// - clock codes select fc/2^11 (fs/2^3 in slow mode or with tap select), fc/2^7, fc/2^3; slow mode blocks 01 and 10, 11 still counts pin edges
// - external trigger timer starts on chosen pin edge, counts source clock
// - stop select 1: match clears, halts, interrupts; opposite edge clears, halts
// - stop select 0: match clears, halts, interrupts; other edges ignored while running
// - pin filter rejects pulses of 4/fc or less outside slow mode; driver holds 12/fc
// - event counter counts chosen pin edge; match interrupts and clears
// - event match is evaluated on the edge opposite the counting edge
// - window mode counts source clock gated by pin level of chosen polarity
// - pulse width mode starts on trigger edge; select picks single or double edge
// - single edge: opposite edge captures, interrupts, counter holds at 1
// - double edge: opposite and trigger edges capture, interrupt; trigger clears
// - new compare value takes effect at first source tick after upper byte write
// - stop power mode forces run field to stop and halts counter
// - auto capture only in timer, event counter and window modes
module tcc_timer_counter (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // axi4-lite write address
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic [2:0]  i_s_axi_awprot,
  // axi4-lite write data
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  // axi4-lite write response
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  // axi4-lite read address
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic [2:0]  i_s_axi_arprot,
  // axi4-lite read data
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  // system state
  input  wire logic        i_slow_mode,
  input  wire logic        i_stop_mode,
  input  wire logic        i_prescaler_tap_sel,
  input  wire logic        i_fs_tick,
  // pin and event
  input  wire logic        i_count_input_pin,
  output logic             o_timer_match_irq
);

  tcc_pkg::tcc_ctrl_t ctrl;
  logic [15:0] cmp_staged;
  logic [15:0] cmp_active;
  logic [15:0] cmp_armed;
  logic        cmp_pending;
  logic [15:0] capture_width_reg;
  logic [15:0] cnt;
  logic        running;
  logic [15:0] next_cnt;
  logic        next_running;
  logic        match_evt;
  logic        cap_evt;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_cmp;
  logic [31:0] wr_cap;

  logic        pin_s1;
  logic        pin_s2;
  logic        pin_filt;
  logic        pin_prev;
  logic [2:0]  filt_cnt;
  logic        pin_rise;
  logic        pin_fall;
  logic        trig_edge;
  logic        opp_edge;

  logic [`TCC_DIV_W-1:0] div;
  logic [2:0]  fs_div;
  logic        fs_tick8;
  logic        src_tick;

  logic        edge_run;
  logic        ext_clk;
  logic        is_timer;
  logic        is_ext;
  logic        is_event;
  logic        is_window;
  logic        is_pulse;
  logic        match;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic tap(input logic [`TCC_DIV_W-1:0] d, input int n);
    logic [`TCC_DIV_W-1:0] m;
    m = `TCC_DIV_W'((1 << n) - 1);
    return (d & m) == m;
  endfunction

  // axi4-lite write path
  assign o_s_axi_awready = !aw_held;
  assign o_s_axi_wready  = !w_held;
  assign wr_fire = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_ctrl = merge({23'h0, ctrl}, wdata_q, wstrb_q);
  assign wr_cmp  = merge({16'h0, cmp_staged}, wdata_q, wstrb_q);
  assign wr_cap  = merge({16'h0, capture_width_reg}, wdata_q, wstrb_q);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && !aw_held) begin
        aw_held  <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (i_s_axi_wvalid && !w_held) begin
        w_held  <= 1'b1;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `TCC_RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      if (awaddr_q[7:2] <= `TCC_OFF_STAT >> 2) begin
        o_s_axi_bresp <= `TCC_RESP_OKAY;
      end else begin
        o_s_axi_bresp <= `TCC_RESP_SLVERR;
      end
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read path
  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= `TCC_RESP_OKAY;
    end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= `TCC_RESP_OKAY;
      unique case ({i_s_axi_araddr[7:2], 2'b00})
        `TCC_OFF_CTRL: o_s_axi_rdata <= {23'h0, ctrl};
        `TCC_OFF_CMP:  o_s_axi_rdata <= {16'h0, cmp_staged};
        `TCC_OFF_CAP:  o_s_axi_rdata <= {16'h0, capture_width_reg};
        `TCC_OFF_STAT: o_s_axi_rdata <= {15'h0, running, cnt};
        default: begin
          o_s_axi_rdata <= 32'h0000_0000;
          o_s_axi_rresp <= `TCC_RESP_SLVERR;
        end
      endcase
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // control register; stop power mode overrides the run field
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= `TCC_CTRL_RST;
    end else begin
      if (wr_fire && awaddr_q == `TCC_OFF_CTRL) begin
        ctrl <= wr_ctrl[`TCC_CTRL_W-1:0];
      end
      if (i_stop_mode) begin
        ctrl.run_edge_sel <= tcc_pkg::TCC_RUN_STOP;
      end
    end
  end

  // compare: staged value goes live on the first source tick after an upper-byte write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_staged  <= `TCC_CMP_RST;
      cmp_armed   <= `TCC_CMP_RST;
      cmp_active  <= `TCC_CMP_RST;
      cmp_pending <= 1'b0;
    end else begin
      if (src_tick && cmp_pending) begin
        cmp_active  <= cmp_armed;
        cmp_pending <= 1'b0;
      end
      // a low-byte-only write stays staged until a later upper-byte write carries it to the live value
      if (wr_fire && awaddr_q == `TCC_OFF_CMP) begin
        cmp_staged <= wr_cmp[15:0];
        if (wstrb_q[`TCC_CMP_HI_LANE]) begin
          cmp_armed   <= wr_cmp[15:0];
          cmp_pending <= 1'b1;
        end
      end
    end
  end

  // pin synchroniser and noise filter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1   <= 1'b0;
      pin_s2   <= 1'b0;
      pin_filt <= 1'b0;
      pin_prev <= 1'b0;
      filt_cnt <= 3'h0;
    end else begin
      pin_s1   <= i_count_input_pin;
      pin_s2   <= pin_s1;
      pin_prev <= pin_filt;
      if (pin_s2 == pin_filt) begin
        filt_cnt <= 3'h0;
      end else if (i_slow_mode || filt_cnt == 3'(`TCC_FILT_ACCEPT_CYC - 1)) begin
        pin_filt <= pin_s2;
        filt_cnt <= 3'h0;
      end else begin
        filt_cnt <= filt_cnt + 3'h1;
      end
    end
  end

  assign pin_rise  = pin_filt && !pin_prev;
  assign pin_fall  = !pin_filt && pin_prev;
  assign trig_edge = (ctrl.run_edge_sel == tcc_pkg::TCC_RUN_RISE) ? pin_rise : pin_fall;
  assign opp_edge  = (ctrl.run_edge_sel == tcc_pkg::TCC_RUN_RISE) ? pin_fall : pin_rise;

  // prescaler
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div    <= '0;
      fs_div <= 3'h0;
    end else begin
      div <= div + `TCC_DIV_W'(1);
      if (i_fs_tick) begin
        fs_div <= fs_div + 3'h1;
      end
    end
  end

  assign fs_tick8 = i_fs_tick && (fs_div == 3'((1 << `TCC_FS_DIV) - 1));

  always_comb begin
    unique case (ctrl.source_clock_sel)
      2'h0: src_tick = (i_slow_mode || i_prescaler_tap_sel) ? fs_tick8
                                                            : tap(div, `TCC_DIV_SLOW);
      2'h1: src_tick = !i_slow_mode && tap(div, `TCC_DIV_MID);
      2'h2: src_tick = !i_slow_mode && tap(div, `TCC_DIV_FAST);
      2'h3: src_tick = trig_edge;
    endcase
  end

  // mode decode
  assign edge_run  = ctrl.run_edge_sel == tcc_pkg::TCC_RUN_RISE ||
                     ctrl.run_edge_sel == tcc_pkg::TCC_RUN_FALL;
  assign ext_clk   = ctrl.source_clock_sel == 2'h3;
  assign is_timer  = ctrl.operating_mode_sel == tcc_pkg::TCC_MODE_BASIC &&
                     ctrl.run_edge_sel == tcc_pkg::TCC_RUN_SW && !ext_clk;
  assign is_ext    = ctrl.operating_mode_sel == tcc_pkg::TCC_MODE_BASIC && edge_run && !ext_clk;
  assign is_event  = ctrl.operating_mode_sel == tcc_pkg::TCC_MODE_BASIC && edge_run && ext_clk;
  assign is_window = ctrl.operating_mode_sel == tcc_pkg::TCC_MODE_WINDOW && edge_run && !ext_clk;
  assign is_pulse  = ctrl.operating_mode_sel == tcc_pkg::TCC_MODE_PULSE && edge_run && !ext_clk;
  assign match     = cnt == cmp_active;

  // counter next state and events
  always_comb begin
    next_cnt     = cnt;
    next_running = running;
    match_evt    = 1'b0;
    cap_evt      = 1'b0;
    if (ctrl.run_edge_sel == tcc_pkg::TCC_RUN_STOP) begin
      next_cnt     = 16'h0000;
      next_running = 1'b0;
    end else if (is_timer) begin
      next_running = 1'b1;
      if (src_tick) begin
        match_evt = match;
        next_cnt  = match ? 16'h0000 : cnt + 16'h0001;
      end
    end else if (is_ext) begin
      if (!running) begin
        next_running = trig_edge;
      end else if (src_tick && match) begin
        match_evt    = 1'b1;
        next_cnt     = 16'h0000;
        next_running = 1'b0;
      end else if (opp_edge && ctrl.trigger_stop_sel) begin
        next_cnt     = 16'h0000;
        next_running = 1'b0;
      end else if (src_tick) begin
        next_cnt = cnt + 16'h0001;
      end
    end else if (is_event) begin
      next_running = 1'b1;
      if (trig_edge) begin
        next_cnt = cnt + 16'h0001;
      end else if (opp_edge && match) begin
        match_evt = 1'b1;
        next_cnt  = 16'h0000;
      end
    end else if (is_window) begin
      next_running = 1'b1;
      if (src_tick && pin_filt == (ctrl.run_edge_sel == tcc_pkg::TCC_RUN_RISE)) begin
        match_evt = match;
        next_cnt  = match ? 16'h0000 : cnt + 16'h0001;
      end
    end else if (is_pulse) begin
      if (!running) begin
        next_running = trig_edge;
      end else if (opp_edge) begin
        cap_evt   = 1'b1;
        match_evt = 1'b1;
        if (ctrl.capture_edge_count_sel) begin
          next_cnt     = 16'h0001;
          next_running = 1'b0;
        end else if (src_tick) begin
          next_cnt = cnt + 16'h0001;
        end
      end else if (trig_edge && !ctrl.capture_edge_count_sel) begin
        cap_evt   = 1'b1;
        match_evt = 1'b1;
        next_cnt  = 16'h0000;
      end else if (src_tick) begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt     <= 16'h0000;
      running <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      running <= next_running;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_timer_match_irq <= 1'b0;
    end else begin
      o_timer_match_irq <= match_evt;
    end
  end

  // capture register; bus writes land only in generator mode
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capture_width_reg <= `TCC_CAP_RST;
    end else if (cap_evt) begin
      capture_width_reg <= cnt;
    end else if (ctrl.auto_capture_en && src_tick && (is_timer || is_event || is_window)) begin
      capture_width_reg <= cnt;
    end else if (wr_fire && awaddr_q == `TCC_OFF_CAP &&
                 ctrl.operating_mode_sel == tcc_pkg::TCC_MODE_PPG) begin
      capture_width_reg <= wr_cap[15:0];
    end
  end

endmodule
`default_nettype wire

// File: tcc_timer_counter_props.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_counter_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // register bus
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic [7:0]  i_s_axi_awaddr,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [7:0]  i_s_axi_araddr,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0]  o_s_axi_rresp,
  // system and event
  input wire logic        i_stop_mode,
  input wire logic        o_timer_match_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire aw_go = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  // unmapped places answer with an error code
  write_resp_a: assert property (aw_go && !o_s_axi_bvalid && i_s_axi_awaddr[1:0] == 2'h0
    |-> ##2 o_s_axi_bvalid && o_s_axi_bresp == ($past(i_s_axi_awaddr, 2) > 8'h0C ? 2'h2 : 2'h0))
    else $error("write response wrong");
  write_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("bvalid dropped early");
  write_end_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("bvalid stayed after bready");
  read_resp_a: assert property (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr[1:0] == 2'h0
    |=> o_s_axi_rvalid && o_s_axi_rresp == ($past(i_s_axi_araddr) > 8'h0C ? 2'h2 : 2'h0))
    else $error("read response wrong");
  read_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data not held");
  read_end_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("rvalid stayed after rready");
  read_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
  irq_pulse_a: assert property (o_timer_match_irq |=> !o_timer_match_irq)
    else $error("event pulse longer than one cycle");
  stop_quiet_a: assert property (i_stop_mode [*3] |-> !o_timer_match_irq)
    else $error("event during stop mode");
  irq_c: cover property (o_timer_match_irq);
  slverr_c: cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
  stop_c: cover property (i_stop_mode [*3]);
endmodule
bind tcc_timer_counter tcc_timer_counter_props i_tcc_timer_counter_props (.*);
`default_nettype wire
